// ===== rtl/chp_pkg.sv
// Purpose: Shared constants for the component handler port.
// Assumes: 250 MHz mclk.
// Notes:   Times are kept in their own unit; cycle counts derive from them.
package chp_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ         = 250;
  localparam int BIN_DELAY_US    = 200;
  // Longest time, exact in cycles; well above 4096 so the bench overrides the top's delay
  localparam int BIN_DELAY_CYC   = BIN_DELAY_US * CLK_MHZ;
  localparam int NUM_BINS        = 9;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic RST_PIN_N     = 1'b1;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CHP_IDLE,
    CHP_CONVERT,
    CHP_MATH,
    CHP_PUBLISH
  } chp_state_t;

endpackage

// ===== rtl/chp_result_if.sv
// Purpose: Carrier for a computed result between the sequencer and the latch.
// Assumes: One clock domain.
// Notes:   load is a one-cycle strobe.
`timescale 1ns/100ps
`default_nettype none
interface chp_result_if #(parameter int NBINS = 9);
  logic             load;
  logic [NBINS-1:0] bin_onehot;
  logic             sec_fail;
  logic             pri_hi;
  logic             pri_lo;

  modport src (output load, output bin_onehot, output sec_fail,
               output pri_hi, output pri_lo);
  modport dst (input load, input bin_onehot, input sec_fail,
               input pri_hi, input pri_lo);
endinterface
`default_nettype wire

// ===== rtl/chp_result_latch.sv
// Purpose: Holds the active-low result pins between updates.
// Assumes: Inputs of the carrier are valid when load is high.
// Notes:   All outputs are flip-flops; high means not asserted.
`timescale 1ns/100ps
`default_nettype none
module chp_result_latch
  import chp_pkg::*;
#(
  parameter int NBINS = 9
) (
  input  wire logic     mclk,
  input  wire logic     rst_n,
  chp_result_if.dst     res,
  output var  logic [NBINS-1:0] bin_n,
  output var  logic     secondary_fail_n,
  output var  logic     primary_high_fail_n,
  output var  logic     primary_low_fail_n,
  output var  logic     primary_fail_n,
  output var  logic     overall_nogood_n
);

  // ----------------------------------------------------------------
  // Per-bin pins
  // ----------------------------------------------------------------
  // One flop per bin, held until the next load
  for (genvar i = 0; i < NBINS; i++) begin : g_bin
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        bin_n[i] <= RST_PIN_N;
      end else if (res.load) begin
        bin_n[i] <= ~res.bin_onehot[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Fail pins
  // ----------------------------------------------------------------
  // Combined pins are computed from the inputs, not from other pins,
  // so every pin changes on the same edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      secondary_fail_n    <= RST_PIN_N;
      primary_high_fail_n <= RST_PIN_N;
      primary_low_fail_n  <= RST_PIN_N;
      primary_fail_n      <= RST_PIN_N;
      overall_nogood_n    <= RST_PIN_N;
    end else if (res.load) begin
      secondary_fail_n    <= ~res.sec_fail;
      primary_high_fail_n <= ~res.pri_hi;
      primary_low_fail_n  <= ~res.pri_lo;
      primary_fail_n      <= ~(res.pri_hi | res.pri_lo);
      overall_nogood_n    <= ~(res.sec_fail | res.pri_hi | res.pri_lo);
    end
  end

endmodule
`default_nettype wire

// ===== rtl/chp_top.sv
// Purpose: Handler port sequencer: trigger in, result and status pins out.
// Assumes: Inputs synchronous to mclk; analog and math engines are outside.
// Notes:   Result and status pins are open-collector images, low is asserted; measure_start and keypad_locked are active high.
`timescale 1ns/100ps
`default_nettype none
module chp_top
  import chp_pkg::*;
#(
  parameter int NBINS        = NUM_BINS,
  parameter int PUBLISH_CYC  = BIN_DELAY_CYC
) (
  input  wire logic             mclk,
  input  wire logic             rst_n,
  input  wire logic             external_trigger_in,
  input  wire logic             keypad_lock_in,
  input  wire logic             secondary_check_on,
  input  wire logic             convert_done,
  input  wire logic             math_done,
  input  wire logic [3:0]       sorted_bin,
  input  wire logic             secondary_fail,
  input  wire logic             primary_above,
  input  wire logic             primary_below,
  output var  logic             measure_start,
  output var  logic             keypad_locked,
  output var  logic [NBINS-1:0] bin_n,
  output var  logic             secondary_fail_n,
  output var  logic             primary_high_fail_n,
  output var  logic             primary_low_fail_n,
  output var  logic             primary_fail_n,
  output var  logic             overall_nogood_n,
  output var  logic             converting_n,
  output var  logic             measurement_done_n
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // The bin code is four bits wide and decoded against a fixed pin count,
  // so any other bin count is refused here rather than mis-sorted
  if (NBINS != NUM_BINS) begin : g_bad_bins
    $error("chp_top: NBINS must be 9");
  end
  if (PUBLISH_CYC < 1 || PUBLISH_CYC > BIN_DELAY_CYC) begin : g_bad_pub
    $error("chp_top: PUBLISH_CYC out of range");
  end

  // Counter sized for the longest legal delay; a shorter delay only
  // moves the compare point, it never wraps
  localparam int CW = $clog2(BIN_DELAY_CYC + 1);
  localparam logic [CW-1:0] PUB_LAST = CW'(PUBLISH_CYC - 1);

  chp_state_t        state;
  logic              trig_q;
  logic              trig_rise;
  logic [CW-1:0]     pub_cnt;
  logic [NBINS-1:0]  cap_bins;
  logic              cap_sec;
  logic              cap_hi;
  logic              cap_lo;

  chp_result_if #(.NBINS(NBINS)) res ();

  // ----------------------------------------------------------------
  // Trigger edge detect
  // ----------------------------------------------------------------
  // Previous level; input is already in the mclk domain
  // Resets to the idle level; a pin already high at release counts as a rise
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trig_q <= 1'b0;
    end else begin
      trig_q <= external_trigger_in;
    end
  end

  assign trig_rise = external_trigger_in & ~trig_q;

  // ----------------------------------------------------------------
  // Keypad lock follower
  // ----------------------------------------------------------------
  // Low on the pin means locked
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      keypad_locked <= 1'b0;
    end else begin
      keypad_locked <= ~keypad_lock_in;
    end
  end

  // ----------------------------------------------------------------
  // Measurement sequencer
  // ----------------------------------------------------------------
  // Edges arriving mid-test are ignored; a test cannot be restarted
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= CHP_IDLE;
    end else begin
      case (state)
        CHP_IDLE: begin
          if (trig_rise) begin
            state <= CHP_CONVERT;
          end
        end
        CHP_CONVERT: begin
          if (convert_done) begin
            state <= CHP_MATH;
          end
        end
        CHP_MATH: begin
          if (math_done) begin
            state <= CHP_PUBLISH;
          end
        end
        CHP_PUBLISH: begin
          if (pub_cnt == PUB_LAST) begin
            state <= CHP_IDLE;
          end
        end
        default: begin
          state <= CHP_IDLE;
        end
      endcase
    end
  end

  // Delay from math done to pin update, bounded by the longest time
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pub_cnt <= '0;
    end else if (state == CHP_PUBLISH) begin
      pub_cnt <= pub_cnt + 1'b1;
    end else begin
      pub_cnt <= '0;
    end
  end

  // Start strobe to the analog engine
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      measure_start <= 1'b0;
    end else begin
      measure_start <= (state == CHP_IDLE) && trig_rise;
    end
  end

  // ----------------------------------------------------------------
  // Status pins
  // ----------------------------------------------------------------
  // Low from trigger until conversion ends, and until the whole test ends
  // Set and clear fall in different states, so they never collide
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      converting_n       <= RST_PIN_N;
      measurement_done_n <= RST_PIN_N;
    end else begin
      if (state == CHP_IDLE && trig_rise) begin
        converting_n       <= 1'b0;
        measurement_done_n <= 1'b0;
      end
      if (state == CHP_CONVERT && convert_done) begin
        converting_n <= 1'b1;
      end
      if (state == CHP_PUBLISH && pub_cnt == PUB_LAST) begin
        measurement_done_n <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Result capture
  // ----------------------------------------------------------------
  // Results are sampled when math ends so later input wiggle is harmless
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cap_bins <= '0;
      cap_sec  <= 1'b0;
      cap_hi   <= 1'b0;
      cap_lo   <= 1'b0;
    end else if (state == CHP_MATH && math_done) begin
      for (int b = 0; b < NBINS; b++) begin
        cap_bins[b] <= (sorted_bin == 4'(b + 1));
      end
      cap_sec <= secondary_fail & secondary_check_on;
      cap_hi  <= primary_above;
      cap_lo  <= primary_below;
    end
  end

  assign res.load       = (state == CHP_PUBLISH) && (pub_cnt == PUB_LAST);
  assign res.bin_onehot = cap_bins;
  assign res.sec_fail   = cap_sec;
  assign res.pri_hi     = cap_hi;
  assign res.pri_lo     = cap_lo;

  chp_result_latch #(.NBINS(NBINS)) u_latch (
    .mclk                (mclk),
    .rst_n               (rst_n),
    .res                 (res),
    .bin_n               (bin_n),
    .secondary_fail_n    (secondary_fail_n),
    .primary_high_fail_n (primary_high_fail_n),
    .primary_low_fail_n  (primary_low_fail_n),
    .primary_fail_n      (primary_fail_n),
    .overall_nogood_n    (overall_nogood_n)
  );

endmodule
`default_nettype wire

// ===== tb/chp_checker.sv
// Purpose: Port-level checks of the handler port.
// Assumes: One clock, async active-low reset.
// Notes:   Bound to chp_top; sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module chp_checker
  import chp_pkg::*;
#(
  parameter int NBINS       = 9,
  parameter int PUBLISH_CYC = 4
) (
  input wire logic             mclk,
  input wire logic             rst_n,
  input wire logic             external_trigger_in,
  input wire logic             keypad_lock_in,
  input wire logic             secondary_check_on,
  input wire logic             convert_done,
  input wire logic             math_done,
  input wire logic [3:0]       sorted_bin,
  input wire logic             secondary_fail,
  input wire logic             primary_above,
  input wire logic             primary_below,
  input wire logic             measure_start,
  input wire logic             keypad_locked,
  input wire logic [NBINS-1:0] bin_n,
  input wire logic             secondary_fail_n,
  input wire logic             primary_high_fail_n,
  input wire logic             primary_low_fail_n,
  input wire logic             primary_fail_n,
  input wire logic             overall_nogood_n,
  input wire logic             converting_n,
  input wire logic             measurement_done_n
);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  localparam int PUB_DLY = PUBLISH_CYC + 1;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // Idle rise starts a test on the next cycle
  a_trig_starts: assert property ((measurement_done_n && $rose(external_trigger_in)) |=>
    (measure_start && !converting_n && !measurement_done_n)) else $error("trigger not taken");
  a_start_pulse: assert property (measure_start |=> !measure_start)
    else $error("start too long");
  a_conv_end: assert property ((!converting_n && convert_done) |=> converting_n)
    else $error("conversion flag stuck");
  a_eom_low: assert property ((!converting_n) |=> !measurement_done_n)
    else $error("done flag early");
  // Results land exactly PUBLISH_CYC+1 cycles after computation ends
  a_result_time: assert property ((math_done && converting_n && !measurement_done_n) |->
    ##PUB_DLY $rose(measurement_done_n)) else $error("result timing wrong");
  a_result_hold: assert property ((measurement_done_n && $past(measurement_done_n)) |->
    ($stable(bin_n) && $stable(overall_nogood_n) && $stable(secondary_fail_n)))
    else $error("result moved while idle");
  a_primary_or: assert property (primary_fail_n == (primary_high_fail_n & primary_low_fail_n))
    else $error("primary fail not or");
  a_nogood_or: assert property (overall_nogood_n == (primary_fail_n & secondary_fail_n))
    else $error("nogood not or");
  a_bin_single: assert property ($countones(~bin_n) <= 1) else $error("two bins low");
  a_lock_follow: assert property ($past(rst_n) |-> keypad_locked == !$past(keypad_lock_in))
    else $error("lock not following");
endmodule

bind chp_top chp_checker #(.NBINS(NBINS), .PUBLISH_CYC(PUBLISH_CYC)) u_chp_checker (
  .mclk(mclk), .rst_n(rst_n), .external_trigger_in(external_trigger_in),
  .keypad_lock_in(keypad_lock_in), .secondary_check_on(secondary_check_on),
  .convert_done(convert_done), .math_done(math_done), .sorted_bin(sorted_bin),
  .secondary_fail(secondary_fail), .primary_above(primary_above),
  .primary_below(primary_below), .measure_start(measure_start),
  .keypad_locked(keypad_locked), .bin_n(bin_n), .secondary_fail_n(secondary_fail_n),
  .primary_high_fail_n(primary_high_fail_n), .primary_low_fail_n(primary_low_fail_n),
  .primary_fail_n(primary_fail_n), .overall_nogood_n(overall_nogood_n),
  .converting_n(converting_n), .measurement_done_n(measurement_done_n));
`default_nettype wire

// ===== tb/chp_engine_model.sv
// Purpose: Stand-in for the conversion and math engines behind the port.
// Assumes: measure_start is a one-cycle pulse.
// Notes:   slow stretches both phases so a mid-test trigger can land.
`timescale 1ns/100ps
`default_nettype none
module chp_engine_model (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic measure_start,
  input  wire logic slow,
  output var  logic convert_done,
  output var  logic math_done
);
  // ----------------------------------------------------------------
  // Phase counter
  // ----------------------------------------------------------------
  logic [7:0] cnt;
  logic [1:0] ph;
  // One-cycle strobes; convert always precedes math
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 8'h00;
      ph <= 2'h0;
      convert_done <= 1'b0;
      math_done <= 1'b0;
    end else begin
      convert_done <= 1'b0;
      math_done <= 1'b0;
      if (measure_start) begin
        cnt <= slow ? 8'h0c : 8'h01;
        ph <= 2'h1;
      end else if (ph != 2'h0) begin
        if (cnt != 8'h00) begin
          cnt <= cnt - 8'h01;
        end else if (ph == 2'h1) begin
          convert_done <= 1'b1;
          cnt <= slow ? 8'h06 : 8'h00;
          ph <= 2'h2;
        end else begin
          math_done <= 1'b1;
          ph <= 2'h0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Purpose: Self-checking bench for the handler port.
// Assumes: Short publish delay of 4 cycles.
// Notes:   Inputs change 1 ns after the rising edge.
`timescale 1ns/100ps
`default_nettype none
module tb;
  import chp_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and wiring
  // ----------------------------------------------------------------
  logic       mclk = 0, rst_n = 0, trig = 0, lock = 1, sec_on = 0, slow = 0;
  logic       sec = 0, hi = 0, lo = 0;
  logic [3:0] bin = 4'h0;
  logic       conv_done, math_done, mstart, locked, sec_n, hi_n, lo_n, pri_n, ng_n;
  logic       conv_n, eom_n;
  logic [8:0] bin_n;
  int         error_cnt = 0, compares = 0;
  always #2 mclk = ~mclk;
  chp_top #(.PUBLISH_CYC(4)) u_chp_top (.mclk(mclk), .rst_n(rst_n),
    .external_trigger_in(trig), .keypad_lock_in(lock), .secondary_check_on(sec_on),
    .convert_done(conv_done), .math_done(math_done), .sorted_bin(bin),
    .secondary_fail(sec), .primary_above(hi), .primary_below(lo), .measure_start(mstart),
    .keypad_locked(locked), .bin_n(bin_n), .secondary_fail_n(sec_n),
    .primary_high_fail_n(hi_n), .primary_low_fail_n(lo_n), .primary_fail_n(pri_n),
    .overall_nogood_n(ng_n), .converting_n(conv_n), .measurement_done_n(eom_n));
  chp_engine_model u_chp_engine_model (.mclk(mclk), .rst_n(rst_n), .measure_start(mstart),
    .slow(slow), .convert_done(conv_done), .math_done(math_done));

  // Compare and count
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    if (error_cnt == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic logic [8:0] exp_bin(input logic [3:0] b);
    logic [8:0] e;
    e = 9'h1ff;
    if (b >= 4'h1 && b <= 4'h9) e[b - 4'h1] = 1'b0;
    return e;
  endfunction

  // One test; called right after an edge so a chained call hits the first idle edge
  task automatic run(input logic [3:0] b, input logic s, h, l, rt);
    int n;
    bin = b; sec = s; hi = h; lo = l; trig = 1;
    @(posedge mclk); #1 trig = 0;
    chk(mstart, 9'h1);
    chk({conv_n, eom_n}, 9'h0);
    // Second trigger mid-test must be ignored
    if (rt) begin
      @(posedge mclk); #1 trig = 1;
      @(posedge mclk); #1 trig = 0;
      chk(mstart, 9'h0);
    end
    n = 0;
    while (eom_n !== 1'b1 && n < 100) begin
      @(posedge mclk); #1 n++;
    end
    chk({eom_n, conv_n}, 9'h3);
    chk(bin_n, exp_bin(b));
    chk(sec_n, !(s && sec_on));
    chk({hi_n, lo_n}, {!h, !l});
    chk(pri_n, !(h || l));
    chk(ng_n, !((s && sec_on) || h || l));
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge mclk);
    #1 rst_n = 1;
    // Every bin code plus out-of-range ones, back to back
    for (int i = 0; i <= 11; i++) begin
      sec_on = (i > 4);
      slow = i[1];
      run(i[3:0], i[0], i % 3 == 1, i % 3 == 2, i[1]);
    end
    // Lock level followed both ways
    for (int v = 0; v < 2; v++) begin
      lock = v[0];
      @(posedge mclk); #1 chk(locked, !v[0]);
    end
    // Reset in mid-test clears every pin
    trig = 1;
    @(posedge mclk); #1 trig = 0;
    repeat (3) @(posedge mclk);
    #1 rst_n = 0;
    #1 chk({bin_n[7:0], ng_n}, 9'h1ff);
    chk({eom_n, conv_n, pri_n, sec_n, mstart, locked}, 9'h3c);
    chk({bin_n[8], hi_n, lo_n}, 9'h7);
    @(posedge mclk); #1 rst_n = 1;
    run(4'h9, 1'b0, 1'b1, 1'b0, 1'b0);
    print_verdict;
  end

  // Watchdog against a hung handshake
  initial begin
    #20000;
    error_cnt++;
    print_verdict;
  end
endmodule
`default_nettype wire
